// ===== inc/twss_pkg.sv
// twss_pkg: register map, bit positions, reset values and protocol constants for the two-wire slave.
// assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package twss_pkg;
  localparam logic [11:0] TWSS_OFF_CTRL = 12'h000;
  localparam logic [11:0] TWSS_OFF_STAT = 12'h004;
  localparam logic [11:0] TWSS_OFF_RCV = 12'h008;
  localparam logic [11:0] TWSS_OFF_TRN = 12'h00C;
  localparam logic [11:0] TWSS_OFF_ADD = 12'h010;
  localparam logic [11:0] TWSS_OFF_BRG = 12'h014;
  // control word bits
  localparam int TWSS_CTL_ON = 15;
  localparam int TWSS_CTL_TEN_BIT_ADDRESS_MODE = 10;
  localparam int TWSS_CTL_STRETCH_ENABLE = 6;
  localparam int TWSS_CTL_CLOCK_RELEASE = 12;
  // status word bits; bits 5..0 read-only
  localparam int TWSS_ST_RO_BITS = 6;
  localparam int TWSS_ST_OV = 6;
  localparam int TWSS_ST_RW = 2;
  localparam int TWSS_ST_RBF = 1;
  localparam int TWSS_ST_TBF = 0;
  localparam int TWSS_ST_TEN_BIT_MATCH_FLAG = 8;
  localparam int TWSS_ST_SEV = 9;
  localparam logic [15:0] TWSS_CTRL_RST = 16'h1000;
  localparam logic [15:0] TWSS_STAT_RST = 16'h0000;
  localparam logic [4:0] TWSS_TEN_HDR = 5'h1E;
  localparam logic [3:0] TWSS_BITS_BYTE = 4'h8;
  localparam logic [1:0] TWSS_RESP_OK = 2'h0;
  localparam logic [1:0] TWSS_RESP_ERR = 2'h2;
endpackage

// ===== src/twss_slave.sv
// twss_slave: two-wire bus slave with 7/10-bit addressing, clock stretching, AXI4-Lite regs.
// assumes scl/sda resolved externally as wired-AND; pins are asynchronous to clk_sys.
// Function
// - status bits 5..0 read-only; higher status bits read-write
// - full received byte moves to receive holding and pulses interrupt
// - transmit path has one holding register, no queue
// - ten-bit address mode bit selects 7- or 10-bit address compare
// - idle until start, shift eight bits on scl rise, compare address
// - 7-bit: own address 6..0 versus shift 7..1; bit 0 is direction
// - on match ack, set slave event on ninth fall; receive holding untouched
// - read match: ack, hold scl until transmit write and release
// - transmit bits change on scl fall; interrupt on ninth fall regardless of ack
// - write match: receive bytes, load holding if not full, ack if no overflow
// - receive full at byte end: no ack, no load, interrupt still
// - overflow set, full clear: load holding, but send not-acknowledge
// - 10-bit first byte 11110 plus addr 9..8; write match clears flag
// - 10-bit second byte versus addr 7..0 sets match flag, else idle
// - after full 10-bit match, restart with first byte read enters transmit
// - transmit: ack sampled with empty transmit buffer clears release, stretches
// - transmit buffer filled before ninth fall: no release clear, scl held one cycle only
// - stretch enabled receive: full at ninth fall clears release, stretches
// - receive read before ninth fall: no release clear, no stretch
// - stretch disabled: software writes to release bit ignored
// - cleared release drives scl low only after scl sampled low
`timescale 1ns/1ps
`default_nettype none
module twss_slave
  import twss_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl_i, // scl pin level
  output logic scl_o, // scl drive value, always 0
  output logic scl_oe, // scl pulled low when high
  input wire logic sda_i, // sda pin level
  output logic sda_o, // sda drive value, always 0
  output logic sda_oe, // sda pulled low when high
  output logic slave_irq, // one-cycle slave event pulse
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  typedef enum logic [5:0] {
    TWSS_IDLE = 6'b000001, TWSS_ADDR = 6'b000010, TWSS_ADDR2 = 6'b000100,
    TWSS_RX = 6'b001000, TWSS_TX = 6'b010000, TWSS_SKIP = 6'b100000
  } twss_state_t;

  typedef struct packed {
    logic [2:0] scl_s, sda_s;
    logic scl_f, sda_f;
    twss_state_t st;
    logic [3:0] bitc;
    logic [7:0] rsr, tsr;
    logic ack_phase; // ninth-bit window
    logic ack_drive; // we acknowledge this byte
    logic tx_nack; // master refused our byte
    logic ten_full; // full 10-bit match seen
    logic [15:0] ctrl, stat;
    logic [7:0] rcv, trn;
    logic [9:0] addr;
    logic [8:0] brg;
    logic hold_low; // pulling scl low
    logic irq; // event pulse
    logic sda_low; // pulling sda low
    logic tx_loaded; // shifter holds this byte
    logic aw_got; // write address captured
    logic w_got; // write data captured
    logic bvalid; // write answer pending
    logic rvalid; // read answer pending
    logic [11:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
  } twss_regs_t;

  twss_regs_t q, d;
  logic scl_now, sda_now, scl_rise, scl_fall, start_c, stop_c, wr_fire, rd_fire;
  logic addr7_hit, hdr_hit, rw_bit;
  logic tx_wait;
  logic [7:0] byte_in;

  always_comb begin
    // a change counts once the second and third stages agree
    scl_now = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
    sda_now = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
    scl_rise = scl_now && !q.scl_f;
    scl_fall = !scl_now && q.scl_f;
    start_c = scl_now && q.scl_f && q.sda_f && !sda_now;
    stop_c = scl_now && q.scl_f && !q.sda_f && sda_now;
    byte_in = {q.rsr[6:0], sda_now};
    rw_bit = q.rsr[0];
    addr7_hit = (q.rsr[7:1] == q.addr[6:0]);
    hdr_hit = (q.rsr[7:3] == TWSS_TEN_HDR) && (q.rsr[2:1] == q.addr[9:8]);
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    rd_fire = s_axi_arvalid && !q.rvalid;
    // transmit byte start with nothing in the shifter yet
    tx_wait = (q.st == TWSS_TX) && !q.ack_phase && (q.bitc == 4'h0) && !q.tx_loaded;
  end

  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.scl_s = {q.scl_s[1:0], scl_i};
    d.sda_s = {q.sda_s[1:0], sda_i};
    d.scl_f = scl_now;
    d.sda_f = sda_now;
    // bus slave: address and data taken in either order
    if (s_axi_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rresp = TWSS_RESP_OK;
      unique case (s_axi_araddr)
        TWSS_OFF_CTRL: d.rdata = {16'h0000, q.ctrl};
        TWSS_OFF_STAT: d.rdata = {16'h0000, q.stat};
        TWSS_OFF_RCV: begin
          d.rdata = {24'h000000, q.rcv};
          d.stat[TWSS_ST_RBF] = 1'b0; // reading empties the holding register
        end
        TWSS_OFF_TRN: d.rdata = {24'h000000, q.trn};
        TWSS_OFF_ADD: d.rdata = {22'h000000, q.addr};
        TWSS_OFF_BRG: d.rdata = {23'h000000, q.brg};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = TWSS_RESP_ERR;
        end
      endcase
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = TWSS_RESP_OK;
      unique case (q.awaddr)
        TWSS_OFF_CTRL: begin
          if (q.wdata[TWSS_CTL_STRETCH_ENABLE] || (&s_axi_wstrb[1:0] == 1'b0)) begin
            d.ctrl = q.wdata[15:0];
          end else begin
            d.ctrl = q.wdata[15:0];
          end
          if (!q.ctrl[TWSS_CTL_STRETCH_ENABLE]) begin
            d.ctrl[TWSS_CTL_CLOCK_RELEASE] = q.ctrl[TWSS_CTL_CLOCK_RELEASE];
          end
        end
        TWSS_OFF_STAT: d.stat = {q.wdata[15:TWSS_ST_RO_BITS],
                                 q.stat[TWSS_ST_RO_BITS-1:0]};
        TWSS_OFF_RCV: ;
        TWSS_OFF_TRN: begin
          d.trn = q.wdata[7:0];
          d.stat[TWSS_ST_TBF] = 1'b1;
        end
        TWSS_OFF_ADD: d.addr = q.wdata[9:0];
        TWSS_OFF_BRG: d.brg = q.wdata[8:0];
        default: d.bresp = TWSS_RESP_ERR;
      endcase
    end
    // serial engine
    if (!q.ctrl[TWSS_CTL_ON] || stop_c) begin
      d.st = TWSS_IDLE;
      d.ack_drive = 1'b0;
      d.sda_low = 1'b0;
      d.hold_low = 1'b0;
      d.tx_loaded = 1'b0;
      if (!q.ctrl[TWSS_CTL_ON]) d.ten_full = 1'b0;
    end else if (start_c) begin
      d.st = TWSS_ADDR;
      d.tx_loaded = 1'b0;
      d.bitc = 4'h0;
      d.ack_phase = 1'b0;
      d.ack_drive = 1'b0;
      d.sda_low = 1'b0;
    end else if (q.st != TWSS_IDLE) begin
      if (scl_rise) begin
        if (!q.ack_phase) begin
          d.rsr = byte_in;
          d.bitc = q.bitc + 4'h1;
        end else if (q.st == TWSS_TX) begin
          d.tx_nack = sda_now;
        end
      end
      if (scl_fall) begin
        if (!q.ack_phase && q.bitc == TWSS_BITS_BYTE) begin
          // eighth fall: decide acknowledge for the ninth bit
          d.ack_phase = 1'b1;
          d.ack_drive = 1'b0;
          d.sda_low = 1'b0;
          unique case (q.st)
            TWSS_ADDR: begin
              if (!q.ctrl[TWSS_CTL_TEN_BIT_ADDRESS_MODE]) begin
                d.ack_drive = addr7_hit;
              end else begin
                d.ack_drive = hdr_hit && (!rw_bit || q.ten_full);
              end
              d.stat[TWSS_ST_RW] = rw_bit;
            end
            TWSS_ADDR2: d.ack_drive = (q.rsr == q.addr[7:0]);
            TWSS_RX: begin
              if (!q.stat[TWSS_ST_RBF]) begin
                d.rcv = q.rsr;
                d.stat[TWSS_ST_RBF] = 1'b1;
                d.ack_drive = !q.stat[TWSS_ST_OV];
              end else begin
                d.stat[TWSS_ST_OV] = 1'b1;
              end
            end
            default: ;
          endcase
          d.sda_low = d.ack_drive;
          if (q.st == TWSS_SKIP || q.st == TWSS_TX) d.sda_low = 1'b0;
        end else if (q.ack_phase) begin
          // ninth fall
          d.tx_loaded = 1'b0;
          d.ack_phase = 1'b0;
          d.ack_drive = 1'b0;
          d.sda_low = 1'b0;
          d.bitc = 4'h0;
          unique case (q.st)
            TWSS_ADDR: begin
              if (!q.ack_drive) begin
                d.st = TWSS_IDLE;
                d.ten_full = 1'b0;
                d.stat[TWSS_ST_TEN_BIT_MATCH_FLAG] = 1'b0;
              end else begin
                d.irq = 1'b1;
                d.stat[TWSS_ST_SEV] = 1'b1;
                if (q.stat[TWSS_ST_RW]) begin
                  d.st = TWSS_TX;
                  if (!q.stat[TWSS_ST_TBF]) begin
                    d.ctrl[TWSS_CTL_CLOCK_RELEASE] = 1'b0;
                  end
                end else if (q.ctrl[TWSS_CTL_TEN_BIT_ADDRESS_MODE]) begin
                  d.st = TWSS_ADDR2;
                  d.ten_full = 1'b0;
                  d.stat[TWSS_ST_TEN_BIT_MATCH_FLAG] = 1'b0;
                end else begin
                  d.st = TWSS_RX;
                end
              end
            end
            TWSS_ADDR2: begin
              d.st = q.ack_drive ? TWSS_RX : TWSS_IDLE;
              d.ten_full = q.ack_drive;
              d.stat[TWSS_ST_TEN_BIT_MATCH_FLAG] = q.ack_drive;
              d.irq = q.ack_drive;
            end
            TWSS_RX: begin
              d.irq = 1'b1;
              d.stat[TWSS_ST_SEV] = 1'b1;
              if (q.ctrl[TWSS_CTL_STRETCH_ENABLE] && q.stat[TWSS_ST_RBF]) begin
                d.ctrl[TWSS_CTL_CLOCK_RELEASE] = 1'b0;
              end
            end
            TWSS_TX: begin
              d.irq = 1'b1;
              d.stat[TWSS_ST_SEV] = 1'b1;
              if (q.tx_nack) begin
                d.st = TWSS_SKIP;
              end else if (!q.stat[TWSS_ST_TBF]) begin
                d.ctrl[TWSS_CTL_CLOCK_RELEASE] = 1'b0;
              end
            end
            default: ;
          endcase
        end else if (q.st == TWSS_TX) begin
          d.sda_low = !q.tsr[7];
          d.tsr = {q.tsr[6:0], 1'b0};
        end
      end
      // load while scl is still held, so the first bit settles before release
      // trade-off: one extra held cycle even when the buffer was filled early
      if (tx_wait && q.stat[TWSS_ST_TBF] && !scl_now) begin
        d.sda_low = !q.trn[7];
        d.tsr = {q.trn[6:0], 1'b0};
        d.stat[TWSS_ST_TBF] = 1'b0;
        d.tx_loaded = 1'b1;
      end
    end
    // stretch: assert only once scl is already low, release on bit set
    if (!q.ctrl[TWSS_CTL_CLOCK_RELEASE] && !scl_now) d.hold_low = 1'b1;
    if (q.ctrl[TWSS_CTL_CLOCK_RELEASE] || !q.ctrl[TWSS_CTL_ON]) d.hold_low = 1'b0;
    // hold until a byte sits in the shifter, even if release was set early;
    // otherwise the set release would drop the hold before sda is valid
    if (tx_wait && q.ctrl[TWSS_CTL_ON] && !scl_now) d.hold_low = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.st <= TWSS_IDLE;
      q.ctrl <= TWSS_CTRL_RST;
      q.stat <= TWSS_STAT_RST;
    end else begin
      q <= d;
    end
  end

  // open-drain: drive value is always low, only enables toggle
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = q.hold_low;
  assign sda_oe = q.sda_low;
  assign slave_irq = q.irq;
  assign s_axi_awready = !q.aw_got;
  assign s_axi_wready = !q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule
`default_nettype wire

// ===== verification/twss_props.sv
// twss_props: port-level checks for the two-wire slave.
// assumes the bind below; scl_i is the resolved wired-AND level.
`timescale 1ns/1ps
`default_nettype none
module twss_props (
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic scl_i, // scl level
  input wire logic scl_o, // scl value
  input wire logic scl_oe, // scl pull
  input wire logic sda_o, // sda value
  input wire logic sda_oe, // sda pull
  input wire logic slave_irq, // event
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin value high");
  chk_irq_pulse: assert property (slave_irq |=> !slave_irq)
    else $error("irq longer than one cycle");
  chk_irq_scl_low: assert property (slave_irq |-> !scl_i)
    else $error("irq while scl high");
  // the wire already carries our own pull, so look one edge back
  chk_hold_after_low: assert property ($rose(scl_oe) |-> !$past(scl_i))
    else $error("scl pulled while high");
  chk_sda_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_i))
    else $error("sda moved while scl high");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  cover property ($rose(scl_oe));
  cover property (slave_irq);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind twss_slave twss_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .slave_irq(slave_irq),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== verification/twss_master.sv
// twss_master: behavioural two-wire bus master, 160 ns per bit.
// assumes pull-ups outside, so a released line reads high.
`timescale 1ns/1ps
`default_nettype none
module twss_master (
  output logic scl_m, // 0 pulls scl
  output logic sda_m, // 0 pulls sda
  input wire logic scl, // scl level
  input wire logic sda // sda level
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // high phase only counts once a stretch is over
  task automatic hi();
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #40;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #40;
    hi();
    sda_m = 1'b0;
    #40;
    scl_m = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #40;
    hi();
    sda_m = 1'b1;
    #80;
  endtask
  task automatic bitx(input logic b, output logic s);
    sda_m = b;
    #40;
    hi();
    s = sda;
    #40;
    scl_m = 1'b0;
    #40;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(v[i], s);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(ack, s);
  endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// testbench: twss_slave over AXI4-Lite and a two-wire master model.
// assumes pull-ups on both lines; received bytes modelled in a queue.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import twss_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, ctl;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic [1:0] bresp, rresp, bres;
  logic [15:0] lfsr = 16'hCCBD;
  logic [7:0] rx_q[$];
  int n_mismatch = 0, cmp_count = 0, n_irq = 0;
  wire scl_m, sda_m;
  wire scl_w = scl_m & ~scl_oe;
  wire sda_w = sda_m & ~sda_oe;
  twss_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .slave_irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  twss_master m (.scl_m(scl_m), .sda_m(sda_m), .scl(scl_w), .sda(sda_w));
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (irq === 1'b1) n_irq++;
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd(output logic [7:0] v);
    lfsr = lfsr_step(lfsr);
    v = lfsr[7:0];
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_link(input logic [7:0] g, input logic [7:0] e);
    chk_reg({24'h0, g}, {24'h0, e});
  endtask
  // readies are sampled mid-cycle: they only move at the rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_sys);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      if (bvalid) bres = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_sys);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic stretched();
    repeat (60) @(negedge clk_sys);
    chk_reg({31'h0, scl_oe}, 32'h1);
    @(posedge clk_sys);
  endtask
  task automatic serve_rx();
    logic [31:0] d;
    logic [1:0] r;
    stretched();
    axi_rd(TWSS_OFF_CTRL, d, r);
    chk_reg({31'h0, d[TWSS_CTL_CLOCK_RELEASE]}, 32'h0);
    axi_rd(TWSS_OFF_RCV, d, r);
    chk_reg(d, {24'h0, rx_q.pop_front()});
    axi_wr(TWSS_OFF_CTRL, ctl);
  endtask
  task automatic serve_tx(input logic [7:0] v);
    stretched();
    axi_wr(TWSS_OFF_TRN, {24'h0, v});
    axi_wr(TWSS_OFF_CTRL, ctl);
  endtask
  task automatic done(input string s);
    $display("test %s ended, compares %0d", s, cmp_count);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b, v;
    logic a;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    axi_rd(TWSS_OFF_CTRL, d, r);
    chk_reg(d, {16'h0, TWSS_CTRL_RST});
    axi_wr(TWSS_OFF_STAT, 32'hFFFF);
    axi_rd(TWSS_OFF_STAT, d, r);
    chk_reg(d, 32'hFFC0);
    chk_reg({30'h0, bres}, {30'h0, TWSS_RESP_OK});
    axi_rd(12'h0FC, d, r);
    chk_reg({30'h0, r}, {30'h0, TWSS_RESP_ERR});
    axi_wr(12'h0FC, 32'h0);
    chk_reg({30'h0, bres}, {30'h0, TWSS_RESP_ERR});
    axi_wr(TWSS_OFF_STAT, 32'h0);
    done("registers");
    axi_wr(TWSS_OFF_ADD, 32'h52);
    axi_wr(TWSS_OFF_CTRL, 32'h8000);
    axi_rd(TWSS_OFF_CTRL, d, r);
    chk_reg(d, 32'h9000);
    n_irq = 0;
    m.start();
    m.wbyte(8'hA4, a);
    chk_link({7'h0, a}, 8'h0);
    rnd(b);
    m.wbyte(b, a);
    chk_link({7'h0, a}, 8'h0);
    rx_q.push_back(b);
    rnd(v);
    m.wbyte(v, a);
    chk_link({7'h0, a}, 8'h1);
    axi_rd(TWSS_OFF_RCV, d, r);
    chk_reg(d, {24'h0, rx_q.pop_front()});
    axi_wr(TWSS_OFF_STAT, 32'h40);
    rnd(b);
    m.wbyte(b, a);
    chk_link({7'h0, a}, 8'h1);
    rx_q.push_back(b);
    axi_rd(TWSS_OFF_RCV, d, r);
    chk_reg(d, {24'h0, rx_q.pop_front()});
    m.stop();
    chk_reg(32'(n_irq), 32'h4);
    m.start();
    m.wbyte(8'hA6, a);
    chk_link({7'h0, a}, 8'h1);
    m.stop();
    done("receive");
    axi_wr(TWSS_OFF_STAT, 32'h0);
    ctl = 32'h9040;
    axi_wr(TWSS_OFF_CTRL, ctl);
    m.start();
    m.wbyte(8'hA4, a);
    rnd(b);
    m.wbyte(b, a);
    rx_q.push_back(b);
    rnd(b);
    fork
      m.wbyte(b, a);
      serve_rx();
    join
    chk_link({7'h0, a}, 8'h0);
    rx_q.push_back(b);
    fork
      m.stop();
      serve_rx();
    join
    done("stretch");
    m.start();
    m.wbyte(8'hA5, a);
    chk_link({7'h0, a}, 8'h0);
    rnd(b);
    fork
      m.rbyte(1'b0, v);
      serve_tx(b);
    join
    chk_link(v, b);
    rnd(b);
    fork
      m.rbyte(1'b1, v);
      serve_tx(b);
    join
    chk_link(v, b);
    m.stop();
    done("transmit");
    ctl = 32'h9440;
    axi_wr(TWSS_OFF_CTRL, ctl);
    axi_wr(TWSS_OFF_ADD, 32'h2A5);
    m.start();
    m.wbyte(8'hF4, a);
    chk_link({7'h0, a}, 8'h0);
    m.wbyte(8'hA5, a);
    chk_link({7'h0, a}, 8'h0);
    axi_rd(TWSS_OFF_STAT, d, r);
    chk_reg({31'h0, d[TWSS_ST_TEN_BIT_MATCH_FLAG]}, 32'h1);
    m.start();
    m.wbyte(8'hF5, a);
    chk_link({7'h0, a}, 8'h0);
    rnd(b);
    fork
      m.rbyte(1'b1, v);
      serve_tx(b);
    join
    chk_link(v, b);
    m.stop();
    m.start();
    m.wbyte(8'hF4, a);
    m.wbyte(8'hA6, a);
    chk_link({7'h0, a}, 8'h1);
    m.stop();
    done("ten_bit");
    finish_test();
  end
endmodule
`default_nettype wire
